// ===== src/snw_pkg.sv
/*
  constants, opcodes and carrier structs for the serial memory command
  decoder; assumes an spi mode 0 host driving chip select and clock
*/
package snw_pkg;
  localparam int         ADDR_W           = 9;
  localparam int         MEM_BYTES        = 512;
  localparam logic [7:0] OP_LATCH_SET     = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR   = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_WRITE_MASK    = 8'hF7;
  localparam logic [7:0] OP_WRITE         = 8'h02;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam int         OP_ABIT          = 3;
  localparam int         WEL_BIT          = 1;
  localparam int         BP_LO_BIT        = 2;
  localparam int         BP_HI_BIT        = 3;
  localparam logic [7:0] STATUS_RESET     = 8'h00;
  localparam logic [2:0] BIT_CNT_RESET    = 3'h0;

  typedef struct packed {
    logic [1:0] protect_select;
    logic       write_enable_latch;
  } snw_status_s;

  typedef struct packed {
    logic                 we;
    logic [ADDR_W-1:0]    addr;
    logic [7:0]           data;
  } snw_mem_req_s;
endpackage

// ===== src/snw_sync.sv
/*
  two flip-flop synchroniser for a group of pin inputs;
  assumes inputs are asynchronous to clk
*/
`timescale 1ns/1ps
module snw_sync
  import snw_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("snw_sync width must be positive");
  end

  always_comb
  begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule

// ===== src/snw_ctrl.sv
/*
  spi command decoder with status register, write enable latch and the
  upper-half write latch defect; assumes spi mode 0, chip select low
  frames, memory array outside answering mem_rdata in the same cycle as addr
*/
`timescale 1ns/1ps
module snw_ctrl
  import snw_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         spi_cs_b,
  input  wire logic         spi_sck,
  input  wire logic         spi_mosi,
  output logic              spi_miso,
  output logic              spi_miso_oe,
  output logic              mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [7:0]        mem_wdata,
  input  wire logic [7:0]   mem_rdata,
  output logic [7:0]        status_out
);
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_WDATA, ST_RDATA, ST_SWRITE, ST_SREAD, ST_IGNORE
  } snw_state_e;

  logic [2:0]   pins_s;
  logic         cs_s, sck_s, mosi_s;
  logic         sck_d_r, sck_d_nxt;
  logic         rise, fall, active;
  snw_state_e   state_r, state_nxt;
  logic [2:0]   bit_cnt_r, bit_cnt_nxt;
  logic [7:0]   shift_r, shift_nxt;
  logic [7:0]   tx_r, tx_nxt;
  logic         abit_r, abit_nxt;
  logic         keep_wel_r, keep_wel_nxt;
  logic         wr_done_r, wr_done_nxt;
  snw_status_s  stat_r, stat_nxt;
  snw_mem_req_s req_r, req_nxt;
  logic         load_rd_r, load_rd_nxt;
  logic         miso_r, miso_nxt;
  logic         oe_r, oe_nxt;
  logic [7:0]   byte_in;
  logic [7:0]   status_val;

  snw_sync #(.WIDTH(3)) u_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    // select enters inverted so the reset value of the stage is idle
    .d     ({~spi_cs_b, spi_sck, spi_mosi}),
    .q     (pins_s)
  );

  assign cs_s    = pins_s[2];
  assign sck_s   = pins_s[1];
  assign mosi_s  = pins_s[0];
  assign rise    = sck_s & ~sck_d_r;
  assign fall    = ~sck_s & sck_d_r;
  assign active  = cs_s;
  assign byte_in = {shift_r[6:0], mosi_s};

  always_comb
  begin
    status_val            = 8'h00;
    status_val[WEL_BIT]   = stat_r.write_enable_latch;
    status_val[BP_LO_BIT] = stat_r.protect_select[0];
    status_val[BP_HI_BIT] = stat_r.protect_select[1];
  end

  always_comb
  begin
    sck_d_nxt    = sck_s;
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    tx_nxt       = tx_r;
    abit_nxt     = abit_r;
    keep_wel_nxt = keep_wel_r;
    wr_done_nxt  = wr_done_r;
    stat_nxt     = stat_r;
    req_nxt      = req_r;
    req_nxt.we   = 1'b0;
    load_rd_nxt  = 1'b0;
    miso_nxt     = miso_r;
    oe_nxt       = oe_r;
    if (!active)
    begin
      state_nxt   = ST_OPCODE;
      bit_cnt_nxt = BIT_CNT_RESET;
      oe_nxt      = 1'b0;
      if (wr_done_r && !keep_wel_r)
        stat_nxt.write_enable_latch = 1'b0;
      wr_done_nxt  = 1'b0;
      keep_wel_nxt = 1'b0;
    end
    else
    begin
      if (load_rd_r)
        tx_nxt = mem_rdata;
      if (fall && (state_r == ST_RDATA || state_r == ST_SREAD))
      begin
        oe_nxt   = 1'b1;
        miso_nxt = tx_r[7];
        tx_nxt   = {tx_r[6:0], 1'b0};
      end
      if (rise)
      begin
        shift_nxt   = byte_in;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7)
        begin
          case (state_r)
            ST_OPCODE:
            begin
              state_nxt = ST_IGNORE;
              if (byte_in == OP_LATCH_SET)
                stat_nxt.write_enable_latch = 1'b1;
              else if (byte_in == OP_LATCH_CLEAR)
                stat_nxt.write_enable_latch = 1'b0;
              else if (byte_in == OP_STATUS_READ)
              begin
                state_nxt = ST_SREAD;
                tx_nxt    = status_val;
              end
              else if (byte_in == OP_STATUS_WRITE)
                state_nxt = stat_r.write_enable_latch ?
                            ST_SWRITE : ST_IGNORE;
              else if ((byte_in & OP_WRITE_MASK) == OP_WRITE
                       || (byte_in & OP_WRITE_MASK) == OP_READ)
              begin
                abit_nxt     = byte_in[OP_ABIT];
                keep_wel_nxt = byte_in[OP_ABIT] & ~byte_in[0];
                state_nxt    = ST_ADDR;
                shift_nxt    = {7'h00, byte_in[0]};
              end
            end
            ST_ADDR:
            begin
              req_nxt.addr = {abit_r, byte_in};
              // read flag has moved up to bit 7 by the last address bit
              if (shift_r[7])
              begin
                state_nxt   = ST_RDATA;
                load_rd_nxt = 1'b1;
              end
              else
                state_nxt = stat_r.write_enable_latch ?
                            ST_WDATA : ST_IGNORE;
            end
            ST_WDATA:
            begin
              req_nxt.we   = 1'b1;
              req_nxt.data = byte_in;
              wr_done_nxt  = 1'b1;
            end
            ST_RDATA:
            begin
              req_nxt.addr = req_r.addr + 9'h001;
              load_rd_nxt  = 1'b1;
            end
            ST_SWRITE:
            begin
              stat_nxt.protect_select = {byte_in[BP_HI_BIT],
                                         byte_in[BP_LO_BIT]};
              wr_done_nxt = 1'b1;
              keep_wel_nxt = 1'b0;
              state_nxt   = ST_IGNORE;
            end
            ST_SREAD:
              tx_nxt = status_val;
            default:
              state_nxt = ST_IGNORE;
          endcase
        end
      end
      if (wr_done_r && req_r.we)
        req_nxt.addr = req_r.addr + 9'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sck_d_r    <= 1'b0;
      state_r    <= ST_OPCODE;
      bit_cnt_r  <= BIT_CNT_RESET;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      abit_r     <= 1'b0;
      keep_wel_r <= 1'b0;
      wr_done_r  <= 1'b0;
      stat_r     <= '0;
      req_r      <= '0;
      load_rd_r  <= 1'b0;
      miso_r     <= 1'b0;
      oe_r       <= 1'b0;
    end
    else
    begin
      sck_d_r    <= sck_d_nxt;
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      tx_r       <= tx_nxt;
      abit_r     <= abit_nxt;
      keep_wel_r <= keep_wel_nxt;
      wr_done_r  <= wr_done_nxt;
      stat_r     <= stat_nxt;
      req_r      <= req_nxt;
      load_rd_r  <= load_rd_nxt;
      miso_r     <= miso_nxt;
      oe_r       <= oe_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      status_out <= STATUS_RESET;
    else
      status_out <= status_val;
  end

  assign spi_miso    = miso_r;
  assign spi_miso_oe = oe_r;
  assign mem_we      = req_r.we;
  assign mem_addr    = req_r.addr;
  assign mem_wdata   = req_r.data;
endmodule

// ===== dv/snw_monitor.sv
/* checker on the command decoder ports;
   assumes it is bound into snw_ctrl */
`timescale 1ns/1ps
module snw_monitor
  import snw_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              spi_cs_b,
  input wire logic              spi_miso_oe,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0]        status_out
);
  logic wr_r;
  logic hi_r;
  // frame wrote a byte, half of first write
  always_ff @(posedge clk)
  begin
    if (!rst_b || $fell(spi_cs_b)) wr_r <= 1'b0;
    else if (mem_we) wr_r <= 1'b1;
    if (mem_we && !wr_r) hi_r <= mem_addr[8];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_end;
    $rose(spi_cs_b) && wr_r;
  endsequence
  property p_rsv;
    status_out[0] == 1'b0 && status_out[7:4] == 4'h0;
  endproperty
  property p_rst;
    disable iff (1'b0) !rst_b |=> status_out == 8'h00;
  endproperty
  property p_we;
    mem_we |-> status_out[1];
  endproperty
  property p_clr;
    s_wr_end ##0 !hi_r |-> ##[1:8] !status_out[1];
  endproperty
  property p_hi;
    s_wr_end ##0 hi_r |-> status_out[1] [*8];
  endproperty
  property p_bp;
    $changed(status_out[3:2]) |-> $past(status_out[1]);
  endproperty
  property p_oe;
    spi_cs_b [*6] |-> !spi_miso_oe;
  endproperty
  property p_one;
    mem_we |=> !mem_we [*8];
  endproperty
  a_rsv: assert property (p_rsv) else $error("rsvd bit");
  a_rst: assert property (p_rst) else $error("reset");
  a_we: assert property (p_we) else $error("locked wr");
  a_clr: assert property (p_clr) else $error("no clear");
  a_hi: assert property (p_hi) else $error("hi clear");
  a_bp: assert property (p_bp) else $error("bp wr");
  a_oe: assert property (p_oe) else $error("oe idle");
  a_one: assert property (p_one) else $error("we pulse");
endmodule

bind snw_ctrl snw_monitor i_mon (.clk, .rst_b, .spi_cs_b, .spi_miso_oe,
  .mem_we, .mem_addr, .status_out);

// ===== dv/snw_host.sv
/* spi host and memory array model;
   assumes mode 0, msb first */
`timescale 1ns/1ps
module snw_host
  import snw_pkg::*;
(
  input wire logic              clk,
  output logic                  spi_cs_b,
  output logic                  spi_sck,
  output logic                  spi_mosi,
  input wire logic              spi_miso,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0]        mem_wdata,
  output logic [7:0]            mem_rdata
);
  logic [7:0] mem [MEM_BYTES];
  initial
  begin
    spi_cs_b = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge clk)
  begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
  // array answers combinationally, in the same cycle as the address changes
  assign mem_rdata = mem[mem_addr];
  // one frame of n bytes, clock still outside it
  task automatic xfer(input int n, input logic [23:0] tx,
                      output logic [23:0] rx);
    rx = 24'h000000;
    // quarter ns offset keeps every pin edge off the clk edges
    @(negedge clk);
    #0.25 spi_cs_b = 1'b0;
    #62.5;
    for (int i = 0; i < n * 8; i++)
    begin
      spi_mosi = tx[n*8-1-i];
      #62.5 spi_sck = 1'b1;
      rx = {rx[22:0], spi_miso};
      #62.5 spi_sck = 1'b0;
    end
    #62.5 spi_cs_b = 1'b1;
    spi_mosi = ~spi_mosi;
    #300;
  endtask
endmodule

// ===== dv/snw_ctrl_tb.sv
/* self-checking bench for snw_ctrl;
   assumes snw_host drives the pins */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module snw_ctrl_tb
  import snw_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              spi_cs_b, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic              miso_w, mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0]        mem_wdata, mem_rdata, status_out;
  logic [23:0]       rx;
  int                errors = 0;
  int                compares = 0;
  always #4 clk = ~clk;
  // released miso shows the inverse of its last level
  assign miso_w = spi_miso_oe ? spi_miso : ~spi_miso;
  snw_ctrl i_dut (.clk, .rst_b, .spi_cs_b, .spi_sck, .spi_mosi,
    .spi_miso, .spi_miso_oe, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .status_out);
  snw_host i_host (.clk, .spi_cs_b, .spi_sck, .spi_mosi,
    .spi_miso(miso_w), .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
  task automatic run(input int n, input logic [23:0] tx);
    i_host.xfer(n, tx, rx);
  endtask
  task automatic t_locked;
    run(2, 24'h0500);
    `CHK(rx[7:0], 8'h00)
    run(3, 24'h0210AA);
    `CHK(i_host.mem[16], 8'h00)
    run(2, 24'h010C);
    `CHK(status_out, 8'h00)
  endtask
  task automatic t_halves;
    for (int h = 0; h < 2; h++)
    begin
      run(1, 24'h06);
      `CHK(status_out, 8'h02)
      run(3, {4'h0, h[0], 3'h2, 8'h21, 7'h2D, h[0]});
      `CHK(i_host.mem[{h[0], 8'h21}], {7'h2D, h[0]})
      `CHK(status_out[1], h[0])
      run(3, {4'h0, h[0], 3'h3, 16'h2100});
      `CHK(rx[7:0], {7'h2D, h[0]})
    end
    run(3, 24'h02307E);
    `CHK(i_host.mem[48], 8'h7E)
    `CHK(status_out[1], 1'b0)
    run(1, 24'h04);
    `CHK(status_out, 8'h00)
    run(3, 24'h0A21FF);
    `CHK(i_host.mem[289], 8'h5B)
  endtask
  task automatic t_status;
    run(1, 24'h06);
    run(2, 24'h01FF);
    `CHK(status_out, 8'h0C)
    run(2, 24'h0500);
    `CHK(rx[7:0], 8'h0C)
    @(negedge clk) rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    `CHK(status_out, 8'h00)
    repeat (5) @(negedge clk);
    run(2, 24'h0500);
    `CHK(rx[7:0], 8'h00)
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    t_locked;
    t_halves;
    t_status;
    complete_run;
  end
  initial
  begin
    #200000;
    errors++;
    complete_run;
  end
endmodule
